// ==== hdl/event_flag_aggregator.sv ====
// What this block does
// R1 - general enables: jitter, ready-low, fifo, prbs
// R2 - converter-0 enables: cal done, pa error
// R3 - converter-1 enables: cal done, pa error
// R4 - clocking enables: dll lost/lock, pll lost/lock
// R5 - all enables and flags reset to zero
// R6 - general flags mirror general enable layout
// R7 - disabled source shows live condition only
// R8 - enabled source latches until software clears
// R9 - latched flag pulls routed pin low
// R10 - write one clears flag, releases pin, unless the condition still stands (set wins)
// R11 - bit 0 is real prbs error
// R12 - three more flag registers mirror enables
// R13 - one route bit per source, pin select
// R14 - write zero no effect; pin low while any
`timescale 1ns/10ps
`default_nettype none
module event_flag_aggregator
   import event_flag_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [event_flag_pkg::ADDR_W-1:0] cfg_addr_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [event_flag_pkg::DATA_W-1:0] cfg_wdata_i,
   output logic [event_flag_pkg::DATA_W-1:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   input wire event_flag_pkg::event_cond_type event_cond_i,
   output logic [1:0] event_out_pin_n_o
);
   import event_flag_pkg::*;

   // ***********************************************
   // register class decode
   // ***********************************************

   // which group an address hits within a block of four
   function automatic logic [GROUPS-1:0] group_hit(input logic [ADDR_W-1:0] addr,
                                                   input logic [ADDR_W-1:0] base);
      logic [GROUPS-1:0] hit;
      hit = '0;
      for (int g = 0; g < GROUPS; g++) begin
         hit[g] = (addr == base + ADDR_W'(g));
      end
      return hit;
   endfunction

   // ***********************************************
   // reset release
   // ***********************************************
   logic rst_meta_q;
   logic rst_n_q;

   // async assert, clocked release so every flop leaves reset together
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ***********************************************
   // condition synchronisers
   // ***********************************************
   event_cond_type cond_sync;

   // conditions come from other clock domains of the converter
   sync_two_flop #(
      .WIDTH(COND_W)
   ) cond_sync_inst (
      .clk_i(clk_i),
      .rst_n_i(rst_n_q),
      .async_i(event_cond_i),
      .sync_o(cond_sync)
   );

   // ***********************************************
   // per-group condition vectors
   // ***********************************************
   logic [DATA_W-1:0] cond_vec [GROUPS];
   logic [DATA_W-1:0] group_mask [GROUPS];

   // general group; ready source flags when ready is low
   always_comb begin
      cond_vec[0] = '0;
      cond_vec[0][REF_JITTER_BIT] = cond_sync.ref_jitter;
      cond_vec[0][LINK_RX_READY_BIT] = ~cond_sync.link_rx_ready;
      cond_vec[0][LANE_FIFO_BIT] = cond_sync.lane_fifo_err;
      cond_vec[0][PRBS_IMAG_BIT] = cond_sync.prbs_imag_err;
      cond_vec[0][PRBS_REAL_BIT] = cond_sync.prbs_real_err; // see R11
   end

   // converter groups share one layout
   always_comb begin
      cond_vec[1] = '0;
      cond_vec[1][CAL_DONE_BIT] = cond_sync.conv0_cal_done;
      cond_vec[1][PA_ERR_BIT] = cond_sync.conv0_pa_err;
      cond_vec[2] = '0;
      cond_vec[2][CAL_DONE_BIT] = cond_sync.conv1_cal_done;
      cond_vec[2][PA_ERR_BIT] = cond_sync.conv1_pa_err;
   end

   // clocking group
   always_comb begin
      cond_vec[3] = '0;
      cond_vec[3][DLL_LOST_BIT] = cond_sync.dll_lost;
      cond_vec[3][DLL_LOCK_BIT] = cond_sync.dll_lock;
      cond_vec[3][PLL_LOST_BIT] = cond_sync.pll_lost;
      cond_vec[3][PLL_LOCK_BIT] = cond_sync.pll_lock;
   end

   // implemented bits; reserved ones never store and read zero
   assign group_mask[0] = GENERAL_MASK; // see R1
   assign group_mask[1] = CONV_MASK; // see R2
   assign group_mask[2] = CONV_MASK; // see R3
   assign group_mask[3] = CLOCKING_MASK; // see R4

   // ***********************************************
   // address decode
   // ***********************************************
   wire [GROUPS-1:0] en_hit = group_hit(cfg_addr_i, EVENT_ENABLE_GENERAL_OFS);
   wire [GROUPS-1:0] flag_hit = group_hit(cfg_addr_i, EVENT_FLAGS_GENERAL_OFS);
   wire [GROUPS-1:0] route_hit = group_hit(cfg_addr_i, EVENT_ROUTE_GENERAL_OFS);

   // ***********************************************
   // per-group enable, route and flag state
   // ***********************************************
   logic [DATA_W-1:0] en_q [GROUPS];
   logic [DATA_W-1:0] route_q [GROUPS];
   logic [DATA_W-1:0] flag_q [GROUPS];
   logic [DATA_W-1:0] flag_d [GROUPS];
   logic [DATA_W-1:0] clr_vec [GROUPS];
   logic [DATA_W-1:0] status_view [GROUPS];
   logic [DATA_W-1:0] pull0_vec [GROUPS];
   logic [DATA_W-1:0] pull1_vec [GROUPS];

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : grp
         // only ones written to the flag register clear
         assign clr_vec[g] = (cfg_wr_i && flag_hit[g]) ? cfg_wdata_i : '0; // see R10, R14

         // set wins over a same-cycle clear so no event is lost;
         // dropping the enable drops the latch too
         assign flag_d[g] = en_q[g] & group_mask[g]
                            & (cond_vec[g] | (flag_q[g] & ~clr_vec[g])); // see R8, R10

         // disabled bits show live condition, enabled ones the latch
         assign status_view[g] = group_mask[g]
                                 & ((en_q[g] & flag_q[g]) | (~en_q[g] & cond_vec[g])); // see R6, R7, R12

         // only latched, enabled sources pull a pin
         assign pull0_vec[g] = flag_q[g] & en_q[g] & ~route_q[g]; // see R9, R13
         assign pull1_vec[g] = flag_q[g] & en_q[g] & route_q[g]; // see R9, R13

         // enables and routes are plain storage of implemented bits
         always_ff @(posedge clk_i or negedge rst_n_q) begin
            if (!rst_n_q) begin
               en_q[g] <= REG_RESET; // see R5
               route_q[g] <= REG_RESET;
               flag_q[g] <= REG_RESET; // see R5
            end else begin
               flag_q[g] <= flag_d[g];
               if (cfg_wr_i && en_hit[g]) begin
                  en_q[g] <= cfg_wdata_i & group_mask[g]; // see R1, R2, R3, R4
               end
               if (cfg_wr_i && route_hit[g]) begin
                  route_q[g] <= cfg_wdata_i & group_mask[g]; // see R13
               end
            end
         end
      end
   endgenerate

   // ***********************************************
   // interrupt pins
   // ***********************************************
   logic pull0_any;
   logic pull1_any;

   // any latched source on a pin holds it low
   always_comb begin
      pull0_any = 1'b0;
      pull1_any = 1'b0;
      for (int k = 0; k < GROUPS; k++) begin
         pull0_any = pull0_any | (|pull0_vec[k]);
         pull1_any = pull1_any | (|pull1_vec[k]);
      end
   end

   logic [1:0] pin_n_q;

   // registered so the pins never glitch on decode
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_n_q <= 2'h3;
      end else begin
         pin_n_q <= {~pull1_any, ~pull0_any}; // see R9, R14
      end
   end

   assign event_out_pin_n_o = pin_n_q;

   // ***********************************************
   // read path
   // ***********************************************
   logic [DATA_W-1:0] rd_mux;

   // one hit at most; unmapped addresses read zero
   always_comb begin
      rd_mux = UNMAPPED_READ;
      for (int k = 0; k < GROUPS; k++) begin
         if (en_hit[k]) begin
            rd_mux = en_q[k];
         end
         if (flag_hit[k]) begin
            rd_mux = status_view[k];
         end
         if (route_hit[k]) begin
            rd_mux = route_q[k];
         end
      end
   end

   logic [DATA_W-1:0] rdata_q;
   logic rvalid_q;

   // data answers one cycle after the read strobe
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= cfg_rd_i;
         if (cfg_rd_i) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign cfg_rdata_o = rdata_q;
   assign cfg_rvalid_o = rvalid_q;

endmodule // event_flag_aggregator
`default_nettype wire

// ==== hdl/event_flag_pkg.sv ====
package event_flag_pkg;

   // ***********************************************
   // widths of the configuration port
   // ***********************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int GROUPS = 4;

   // ***********************************************
   // register offsets
   // ***********************************************
   localparam logic [ADDR_W-1:0] EVENT_ENABLE_GENERAL_OFS = 12'h020;
   localparam logic [ADDR_W-1:0] EVENT_ENABLE_CONV0_OFS = 12'h021;
   localparam logic [ADDR_W-1:0] EVENT_ENABLE_CONV1_OFS = 12'h022;
   localparam logic [ADDR_W-1:0] EVENT_ENABLE_CLOCKING_OFS = 12'h023;
   localparam logic [ADDR_W-1:0] EVENT_FLAGS_GENERAL_OFS = 12'h024;
   localparam logic [ADDR_W-1:0] EVENT_FLAGS_CONV0_OFS = 12'h025;
   localparam logic [ADDR_W-1:0] EVENT_FLAGS_CONV1_OFS = 12'h026;
   localparam logic [ADDR_W-1:0] EVENT_FLAGS_CLOCKING_OFS = 12'h027;
   localparam logic [ADDR_W-1:0] EVENT_ROUTE_GENERAL_OFS = 12'h028;
   localparam logic [ADDR_W-1:0] EVENT_ROUTE_CONV0_OFS = 12'h029;
   localparam logic [ADDR_W-1:0] EVENT_ROUTE_CONV1_OFS = 12'h02A;
   localparam logic [ADDR_W-1:0] EVENT_ROUTE_CLOCKING_OFS = 12'h02B;

   // ***********************************************
   // implemented bits of each group, reset values
   // ***********************************************
   localparam logic [DATA_W-1:0] GENERAL_MASK = 8'h1F;
   localparam logic [DATA_W-1:0] CONV_MASK = 8'h09;
   localparam logic [DATA_W-1:0] CLOCKING_MASK = 8'h33;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

   // ***********************************************
   // bit positions
   // ***********************************************
   localparam int REF_JITTER_BIT = 4;
   localparam int LINK_RX_READY_BIT = 3;
   localparam int LANE_FIFO_BIT = 2;
   localparam int PRBS_IMAG_BIT = 1;
   localparam int PRBS_REAL_BIT = 0;
   localparam int CAL_DONE_BIT = 3;
   localparam int PA_ERR_BIT = 0;
   localparam int DLL_LOST_BIT = 5;
   localparam int DLL_LOCK_BIT = 4;
   localparam int PLL_LOST_BIT = 1;
   localparam int PLL_LOCK_BIT = 0;

   // ***********************************************
   // raw conditions from the rest of the chip
   // ***********************************************
   typedef struct packed {
      logic ref_jitter;
      logic link_rx_ready;
      logic lane_fifo_err;
      logic prbs_imag_err;
      logic prbs_real_err;
      logic conv0_cal_done;
      logic conv0_pa_err;
      logic conv1_cal_done;
      logic conv1_pa_err;
      logic dll_lost;
      logic dll_lock;
      logic pll_lost;
      logic pll_lock;
   } event_cond_type;

   localparam int COND_W = $bits(event_cond_type);

endpackage

// ==== hdl/sync_two_flop.sv ====
`timescale 1ns/10ps
`default_nettype none
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // sync_two_flop
`default_nettype wire

// ==== tb/event_flag_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module event_flag_monitor
   import event_flag_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [event_flag_pkg::ADDR_W-1:0] cfg_addr_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [event_flag_pkg::DATA_W-1:0] cfg_wdata_i,
   input wire logic [event_flag_pkg::DATA_W-1:0] cfg_rdata_o,
   input wire logic cfg_rvalid_o,
   input wire event_flag_pkg::event_cond_type event_cond_i,
   input wire logic [1:0] event_out_pin_n_o
);
   // *****
   // register port and pin checks
   // *****
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // enable write followed at once by its read-back
   sequence s_en_wr;
      cfg_wr_i && cfg_addr_i == EVENT_ENABLE_GENERAL_OFS;
   endsequence
   sequence s_en_rd;
      cfg_rd_i && cfg_addr_i == EVENT_ENABLE_GENERAL_OFS;
   endsequence
   a_read_answered: assert property (cfg_rd_i |=> cfg_rvalid_o)
      else $error("read not answered");
   a_answer_single: assert property (cfg_rvalid_o && !cfg_rd_i |=> !cfg_rvalid_o)
      else $error("read answer too long");
   a_data_holds: assert property (!cfg_rvalid_o |-> $stable(cfg_rdata_o))
      else $error("read data moved");
   a_en_readback: assert property (s_en_wr ##1 s_en_rd |=>
      cfg_rdata_o == ($past(cfg_wdata_i, 2) & GENERAL_MASK))
      else $error("enable readback wrong");
   a_flag_reserved: assert property (cfg_rd_i && cfg_addr_i == EVENT_FLAGS_GENERAL_OFS
      |=> cfg_rdata_o[7:5] == 3'h0)
      else $error("reserved flag bits set");
   a_unmapped_zero: assert property (cfg_rd_i && (cfg_addr_i < 12'h020 || cfg_addr_i > 12'h02B)
      |=> cfg_rdata_o == UNMAPPED_READ)
      else $error("unmapped read not zero");
   a_quiet_reset: assert property ($rose(rst_n_i) |-> (event_out_pin_n_o == 2'b11) [*3])
      else $error("pin low after reset");
   a_release_write: assert property ($rose(event_out_pin_n_o[0]) || $rose(event_out_pin_n_o[1])
      |-> $past(cfg_wr_i, 2) || $past(cfg_wr_i, 3))
      else $error("pin released without write");
endmodule // event_flag_monitor
bind event_flag_aggregator event_flag_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
   .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
   .event_cond_i(event_cond_i), .event_out_pin_n_o(event_out_pin_n_o));
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_model
   import event_flag_pkg::*;
(
   input wire logic clk_i,
   output logic [event_flag_pkg::ADDR_W-1:0] cfg_addr_o,
   output logic cfg_wr_o,
   output logic cfg_rd_o,
   output logic [event_flag_pkg::DATA_W-1:0] cfg_wdata_o,
   input wire logic [event_flag_pkg::DATA_W-1:0] cfg_rdata_i,
   input wire logic cfg_rvalid_i
);
   // *****
   // configuration port master
   // *****
   // idle strobes from time zero
   initial begin
      cfg_addr_o = 12'h000;
      cfg_wr_o = 1'b0;
      cfg_rd_o = 1'b0;
      cfg_wdata_o = 8'h00;
   end
   // one-cycle write; a one in a flag register clears it
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      cfg_addr_o <= a;
      cfg_wdata_o <= d;
      cfg_wr_o <= 1'b1;
      @(posedge clk_i);
      cfg_wr_o <= 1'b0;
      cfg_wdata_o <= ~d; // stale data never looks valid
   endtask
   // read, bounded wait for the answer
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
      output logic ok);
      int i;
      cfg_addr_o <= a;
      cfg_rd_o <= 1'b1;
      @(posedge clk_i);
      cfg_rd_o <= 1'b0;
      ok = 1'b0;
      for (i = 0; i < 4 && !ok; i++) begin
         @(posedge clk_i);
         ok = (cfg_rvalid_i === 1'b1);
      end
      d = cfg_rdata_i;
   endtask
endmodule // host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import event_flag_pkg::*;
   localparam logic [12:0] IDLE = 13'h0800; // ready high is the quiet state
   localparam logic [19:0] ROWS [10] = '{{12'h020, GENERAL_MASK}, {12'h021, CONV_MASK},
      {12'h022, CONV_MASK}, {12'h023, CLOCKING_MASK}, {12'h028, GENERAL_MASK},
      {12'h029, CONV_MASK}, {12'h02A, CONV_MASK}, {12'h02B, CLOCKING_MASK},
      {12'h030, 8'h00}, {12'h01F, 8'h00}};
   localparam logic [7:0] SRC_OFS [13] = '{8'h23, 8'h23, 8'h23, 8'h23, 8'h22, 8'h22,
      8'h21, 8'h21, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
   localparam int SRC_BIT [13] = '{0, 1, 4, 5, 0, 3, 0, 3, 0, 1, 2, 3, 4};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [ADDR_W-1:0] cfg_addr;
   logic cfg_wr;
   logic cfg_rd;
   logic [DATA_W-1:0] cfg_wdata;
   logic [DATA_W-1:0] cfg_rdata;
   logic cfg_rvalid;
   event_cond_type cond = IDLE;
   logic [1:0] pin_n;
   int checks = 0;
   int n_fail = 0;
   int k;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] m;
   logic r;
   // *****
   // clock, design and host
   // *****
   always #5 clk_i = ~clk_i;
   event_flag_aggregator uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_addr_i(cfg_addr),
      .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
      .cfg_rvalid_o(cfg_rvalid), .event_cond_i(cond), .event_out_pin_n_o(pin_n));
   host_model host (.clk_i(clk_i), .cfg_addr_o(cfg_addr), .cfg_wr_o(cfg_wr),
      .cfg_rd_o(cfg_rd), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata),
      .cfg_rvalid_i(cfg_rvalid));
   // *****
   // helpers
   // *****
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      logic ok;
      host.rd_reg(ad, d, ok);
      if (!ok) begin
         n_fail++;
         $display("mismatch at %0t: no read answer", $time);
         stop_test();
      end else begin
         check(d, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // *****
   // main sequence
   // *****
   initial begin
      tick(10);
      rst_n_i <= 1'b1;
      tick(3);
      // reset value, write all ones, mask read back, restore
      for (k = 0; k < 10; k++) begin
         rd_chk(ROWS[k][19:8], 8'h00);
         host.wr_reg(ROWS[k][19:8], 8'hFF);
         rd_chk(ROWS[k][19:8], ROWS[k][7:0]);
         host.wr_reg(ROWS[k][19:8], 8'h00);
      end
      // every source: live view, then latch, route, clear
      for (k = 0; k < 13; k++) begin
         a = {4'h0, SRC_OFS[k]};
         m = 8'h01 << SRC_BIT[k];
         r = k[0];
         cond <= IDLE ^ (13'h1 << k);
         tick(4);
         rd_chk(a + 12'h004, m);
         check({6'h0, pin_n}, 8'h03);
         cond <= IDLE;
         tick(4);
         rd_chk(a + 12'h004, 8'h00);
         host.wr_reg(a + 12'h008, r ? m : 8'h00);
         tick(1); // strobe drops for an edge between writes
         host.wr_reg(a, m);
         cond <= IDLE ^ (13'h1 << k);
         tick(3);
         cond <= IDLE;
         tick(6);
         check({6'h0, pin_n}, r ? 8'h01 : 8'h02);
         rd_chk(a + 12'h004, m);
         host.wr_reg(a + 12'h004, 8'h00);
         rd_chk(a + 12'h004, m);
         check({6'h0, pin_n}, r ? 8'h01 : 8'h02);
         host.wr_reg(a + 12'h004, m);
         tick(3);
         check({6'h0, pin_n}, 8'h03);
         rd_chk(a + 12'h004, 8'h00);
         host.wr_reg(a, 8'h00);
      end
      tick(1);
      // reset in mid-run drops a latched event
      host.wr_reg(12'h020, 8'h01);
      cond <= IDLE ^ 13'h0100;
      tick(8);
      // clear while the condition still stands: set wins
      host.wr_reg(12'h024, 8'h01);
      rd_chk(12'h024, 8'h01);
      check({6'h0, pin_n}, 8'h02);
      rst_n_i <= 1'b0;
      tick(2);
      check({6'h0, pin_n}, 8'h03);
      rst_n_i <= 1'b1;
      cond <= IDLE;
      tick(3);
      rd_chk(12'h020, 8'h00);
      rd_chk(12'h024, 8'h00);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
